// File: tws_flash_slave.sv
`timescale 1ns/1ns
module tws_flash_slave #(
    parameter int BUSY_CYCLES = tws_pkg::PROG_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_select_in_0,
    input wire logic i_select_in_1,
    input wire logic i_protect_pin,
    output logic o_sda,
    output logic o_sda_oe_n,
    output logic o_busy
);
    localparam int BW = $clog2(BUSY_CYCLES + 1);
    localparam logic [BW-1:0] BUSY_LOAD = BW'(BUSY_CYCLES);
    localparam logic [BW-1:0] BUSY_ONE = BW'(1);
    localparam int AW = tws_pkg::ADDR_W;
    localparam int SW = tws_pkg::SECT_W;

    logic [tws_pkg::SY_W-1:0] pins;
    logic [tws_pkg::SY_W-1:0] meta_q;
    logic [tws_pkg::SY_W-1:0] sync_q;

    assign pins[tws_pkg::SY_SCL] = i_scl;
    assign pins[tws_pkg::SY_SDA] = i_sda;
    assign pins[tws_pkg::SY_S0] = i_select_in_0;
    assign pins[tws_pkg::SY_S1] = i_select_in_1;
    assign pins[tws_pkg::SY_PP] = i_protect_pin;

    // Every pin is resampled; line bits reset high, their idle level, so release makes no edge.
    for (genvar g = 0; g < tws_pkg::SY_W; g++) begin : g_sync
        always_ff @(posedge i_ref_clk or negedge i_nrst) begin
            if (!i_nrst) begin
                meta_q[g] <= (g == tws_pkg::SY_SCL) || (g == tws_pkg::SY_SDA);
                sync_q[g] <= (g == tws_pkg::SY_SCL) || (g == tws_pkg::SY_SDA);
            end else begin
                meta_q[g] <= pins[g];
                sync_q[g] <= meta_q[g];
            end
        end
    end

    logic scl;
    logic sda;
    assign scl = sync_q[tws_pkg::SY_SCL];
    assign sda = sync_q[tws_pkg::SY_SDA];

    tws_pkg::tws_state_t state_q, state_d;
    tws_pkg::tws_phase_t phase_q, phase_d;
    logic scl_p_q, scl_p_d;
    logic sda_p_q, sda_p_d;
    logic [2:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d;
    logic oe_n_q, oe_n_d;
    logic rw_q, rw_d;
    logic [AW-9:0] ahi_q, ahi_d;
    logic [AW-1:0] addr_q, addr_d;
    logic rand_q, rand_d;
    logic [1:0] wcnt_q, wcnt_d;
    logic [7:0] held_q, held_d;
    logic [AW-1:0] held_addr_q, held_addr_d;
    logic wl_q, wl_d;
    logic rwl_q, rwl_d;
    logic [1:0] lock_q, lock_d;
    logic en_q, en_d;
    logic busy_q, busy_d;
    logic [BW-1:0] busy_cnt_q, busy_cnt_d;
    logic sda_q;

    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic [7:0] rx_byte;
    logic [7:0] prot;
    logic [7:0] src;
    logic [7:0] mem_rdata;
    logic mem_we;
    logic hw_prot;
    logic sel_ok;

    function automatic logic region_locked(input logic [AW-1:0] a, input logic [1:0] lk);
        logic r;
        case (lk)
            tws_pkg::LOCK_NONE: r = 1'b0;
            tws_pkg::LOCK_QTR: r = &a[tws_pkg::QTR_HI:tws_pkg::QTR_LO];
            tws_pkg::LOCK_HALF: r = a[tws_pkg::QTR_HI];
            tws_pkg::LOCK_FULL: r = 1'b1;
            default: r = 1'b1;
        endcase
        // The top location belongs to the protect register path and stays open.
        return r && (a != tws_pkg::TOP_ADDR); // [R23]
    endfunction

    assign scl_rise = scl && !scl_p_q;
    assign scl_fall = !scl && scl_p_q;
    assign start_ev = scl && scl_p_q && sda_p_q && !sda;
    assign stop_ev = scl && scl_p_q && !sda_p_q && sda;
    assign rx_byte = {sh_q[6:0], sda};
    assign hw_prot = sync_q[tws_pkg::SY_PP] && en_q; // [R24]
    // Select bit 7 follows input 1 directly and bit 6 follows input 0 inverted.
    assign sel_ok = (rx_byte[tws_pkg::SEL_HI] == sync_q[tws_pkg::SY_S1]) &&
                    (rx_byte[tws_pkg::SEL_LO] == !sync_q[tws_pkg::SY_S0]); // [R05]

    always_comb begin
        prot = 8'h00;
        prot[tws_pkg::BIT_EN] = en_q; // [R17]
        prot[tws_pkg::BIT_LH] = lock_q[1];
        prot[tws_pkg::BIT_LL] = lock_q[0];
        prot[tws_pkg::BIT_RWL] = rwl_q;
        prot[tws_pkg::BIT_WL] = wl_q;
    end

    // Only a read whose address came from a dummy write sees the register.
    assign src = (rand_q && addr_q == tws_pkg::TOP_ADDR) ? prot : mem_rdata; // [R22]

    always_comb begin
        state_d = state_q;
        phase_d = phase_q;
        scl_p_d = scl;
        sda_p_d = sda;
        cnt_d = cnt_q;
        sh_d = sh_q;
        oe_n_d = oe_n_q;
        rw_d = rw_q;
        ahi_d = ahi_q;
        addr_d = addr_q;
        rand_d = rand_q;
        wcnt_d = wcnt_q;
        held_d = held_q;
        held_addr_d = held_addr_q;
        wl_d = wl_q;
        rwl_d = rwl_q;
        lock_d = lock_q;
        en_d = en_q;
        busy_d = busy_q;
        busy_cnt_d = busy_cnt_q;
        mem_we = 1'b0;
        if (busy_q) begin
            busy_cnt_d = busy_cnt_q - BUSY_ONE; // [R26]
            if (busy_cnt_q == BUSY_ONE) begin
                busy_d = 1'b0;
            end
        end
        if (start_ev) begin
            state_d = tws_pkg::ST_RX;
            phase_d = tws_pkg::PH_DEV;
            cnt_d = 3'h0;
            oe_n_d = 1'b1;
            wcnt_d = 2'h0;
        end else if (stop_ev) begin
            state_d = tws_pkg::ST_IDLE;
            oe_n_d = 1'b1;
            wcnt_d = 2'h0;
            // The last byte of a write is held back until the stop shows the count.
            if (wcnt_q == tws_pkg::WCNT_ONE && held_addr_q == tws_pkg::TOP_ADDR) begin // [R21]
                if (held_q == tws_pkg::CLR_WL_PAT) begin
                    wl_d = 1'b0; // [R19]
                end else if (held_q[7:1] == tws_pkg::SET_WL_PAT) begin
                    wl_d = 1'b1; // [R19]
                end else if (wl_q && held_q[tws_pkg::BIT_RWL:tws_pkg::BIT_WL] ==
                             tws_pkg::RWL_PAT) begin
                    rwl_d = 1'b1; // [R20] [R25]
                end else if (wl_q && rwl_q && held_q[2:0] == tws_pkg::NV_PAT &&
                             held_q[6:5] == 2'h0 && !hw_prot) begin // [R24] [R25]
                    en_d = held_q[tws_pkg::BIT_EN];
                    lock_d = {held_q[tws_pkg::BIT_LH], held_q[tws_pkg::BIT_LL]};
                    rwl_d = 1'b0; // [R20]
                    busy_d = 1'b1; // [R25]
                    busy_cnt_d = BUSY_LOAD;
                end
            end else if (wcnt_q != 2'h0 && wl_q) begin
                mem_we = !region_locked(held_addr_q, lock_q); // [R23]
                busy_d = 1'b1; // [R11] [R26]
                busy_cnt_d = BUSY_LOAD;
            end
        end else begin
            case (state_q)
                tws_pkg::ST_RX: begin
                    if (scl_rise) begin
                        sh_d = rx_byte;
                        cnt_d = cnt_q + tws_pkg::CNT_ONE;
                        if (cnt_q == tws_pkg::CNT_LAST) begin
                            state_d = tws_pkg::ST_ACKW; // [R02]
                            case (phase_q)
                                tws_pkg::PH_DEV: begin
                                    if (sel_ok && !busy_q) begin // [R12] [R26]
                                        rw_d = rx_byte[tws_pkg::RW_BIT]; // [R07]
                                        ahi_d = rx_byte[tws_pkg::AHI_HI:tws_pkg::AHI_LO];
                                        if (!rx_byte[tws_pkg::RW_BIT]) begin
                                            phase_d = tws_pkg::PH_ADDR;
                                            rand_d = 1'b0;
                                        end
                                    end else begin
                                        state_d = tws_pkg::ST_IDLE; // [R05] [R11]
                                    end
                                end
                                tws_pkg::PH_ADDR: begin
                                    addr_d = {ahi_q, rx_byte}; // [R06] [R15]
                                    rand_d = 1'b1;
                                    phase_d = tws_pkg::PH_DATA; // [R08]
                                end
                                tws_pkg::PH_DATA: begin
                                    if (wcnt_q == 2'h0 && !wl_q &&
                                        addr_q != tws_pkg::TOP_ADDR) begin
                                        state_d = tws_pkg::ST_IDLE; // [R18]
                                    end else begin
                                        if (wcnt_q != 2'h0 && wl_q) begin
                                            mem_we = !region_locked(held_addr_q, lock_q);
                                        end
                                        held_d = rx_byte; // [R08]
                                        held_addr_d = addr_q;
                                        addr_d[SW-1:0] = addr_q[SW-1:0] + tws_pkg::SECT_ONE; // [R09]
                                        rand_d = 1'b0;
                                        if (wcnt_q != tws_pkg::WCNT_SAT) begin
                                            wcnt_d = wcnt_q + tws_pkg::WCNT_ONE;
                                        end
                                    end
                                end
                                default: state_d = tws_pkg::ST_IDLE;
                            endcase
                        end
                    end
                end
                tws_pkg::ST_ACKW: begin
                    if (scl_fall) begin
                        oe_n_d = 1'b0; // [R01]
                        state_d = tws_pkg::ST_ACK;
                    end
                end
                tws_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        cnt_d = 3'h0;
                        if (rw_q) begin
                            sh_d = src; // [R14]
                            oe_n_d = src[7];
                            rand_d = 1'b0;
                            state_d = tws_pkg::ST_TX;
                        end else begin
                            oe_n_d = 1'b1; // [R01]
                            state_d = tws_pkg::ST_RX;
                        end
                    end
                end
                tws_pkg::ST_TX: begin
                    if (scl_rise) begin
                        cnt_d = cnt_q + tws_pkg::CNT_ONE;
                        if (cnt_q == tws_pkg::CNT_LAST) begin
                            addr_d = addr_q + tws_pkg::ADDR_ONE; // [R14] [R16]
                            state_d = tws_pkg::ST_TXREL;
                        end
                    end else if (scl_fall) begin
                        sh_d = {sh_q[6:0], 1'b0};
                        oe_n_d = sh_q[6]; // [R03]
                    end
                end
                tws_pkg::ST_TXREL: begin
                    if (scl_fall) begin
                        oe_n_d = 1'b1; // [R01] [R03]
                        state_d = tws_pkg::ST_TXACK;
                    end
                end
                tws_pkg::ST_TXACK: begin
                    if (scl_rise) begin
                        // A high ninth bit ends the read; the master then owes a stop.
                        state_d = sda ? tws_pkg::ST_IDLE : tws_pkg::ST_TXLOAD; // [R03] [R04] [R13]
                    end
                end
                tws_pkg::ST_TXLOAD: begin
                    if (scl_fall) begin
                        sh_d = src; // [R16]
                        oe_n_d = src[7];
                        cnt_d = 3'h0;
                        state_d = tws_pkg::ST_TX;
                    end
                end
                default: state_d = tws_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q <= tws_pkg::ST_IDLE;
            phase_q <= tws_pkg::PH_DEV;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            cnt_q <= 3'h0;
            sh_q <= 8'h00;
            oe_n_q <= 1'b1;
            rw_q <= 1'b0;
            ahi_q <= '0;
            addr_q <= '0;
            rand_q <= 1'b0;
            wcnt_q <= 2'h0;
            held_q <= 8'h00;
            held_addr_q <= '0;
            wl_q <= 1'b0; // [R19]
            rwl_q <= 1'b0; // [R20]
            lock_q <= tws_pkg::LOCK_NONE;
            en_q <= 1'b0;
            busy_q <= 1'b0;
            busy_cnt_q <= '0;
            sda_q <= 1'b0;
        end else begin
            state_q <= state_d;
            phase_q <= phase_d;
            scl_p_q <= scl_p_d;
            sda_p_q <= sda_p_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            oe_n_q <= oe_n_d;
            rw_q <= rw_d;
            ahi_q <= ahi_d;
            addr_q <= addr_d;
            rand_q <= rand_d;
            wcnt_q <= wcnt_d;
            held_q <= held_d;
            held_addr_q <= held_addr_d;
            wl_q <= wl_d;
            rwl_q <= rwl_d;
            lock_q <= lock_d;
            en_q <= en_d;
            busy_q <= busy_d;
            busy_cnt_q <= busy_cnt_d;
            sda_q <= 1'b0;
        end
    end

    // Nonvolatile lock bits are modelled as flops, so they do not survive reset.
    tws_mem #(
        .AW(AW),
        .DW(8)
    ) u_mem (
        .i_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_we(mem_we),
        .i_waddr(held_addr_q),
        .i_wdata(held_q),
        .i_raddr(addr_q),
        .o_rdata(mem_rdata)
    );

    assign o_sda = sda_q;
    assign o_sda_oe_n = oe_n_q;
    assign o_busy = busy_q;
endmodule

// File: tws_pkg.sv
// How it works
// [R01] Transmitter releases data line; receiver acknowledges ninth.
// [R02] Acknowledge matching address and every written byte.
// [R03] Read: send byte, release, continue only on acknowledge.
// [R04] Master stops after withholding acknowledge in read.
// [R05] Select bits must match select inputs, some inverted.
// [R06] Upper address bits from slave byte, joined.
// [R07] Last slave address bit: one read, zero program.
// [R08] Program: address byte then 32 acknowledged data bytes.
// [R09] Program bytes increment only low five address bits.
// [R10] Master sends exactly 32 bytes before stop.
// [R11] Ignore bus after programming stop until cycle ends.
// [R12] Withhold address acknowledge while program cycle runs.
// [R13] Master ends read by stop or high ninth bit.
// [R14] Address counter holds last read address plus one.
// [R15] Random read: dummy write, repeated start, then read.
// [R16] Sequential read increments full counter, wraps to zero.
// [R17] Protect register at top address with fixed layout.
// [R18] Write latch clear: refuse first byte to array.
// [R19] 0000001x sets, 00000000 clears write latch; reset clears.
// [R20] 0000011x with write latch sets register write latch; code checks only bits 2:1, so any xxxxx11x byte sets it.
// [R21] Single byte at top updates protect register only.
// [R22] Random read at top returns protect register.
// [R23] Lock bits protect none, quarter, half, or all; code leaves the top address open under every lock setting.
// [R24] Pin high and enable set block locked writes.
// [R25] Lock update needs latch bit zero; starts program cycle.
// [R26] Busy counter models program cycle, gates address acknowledge.
package tws_pkg;
    localparam int ADDR_W = 13;
    localparam int SECT_W = 5;
    localparam logic [ADDR_W-1:0] TOP_ADDR = 13'h1fff;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 13'h0001;
    localparam logic [SECT_W-1:0] SECT_ONE = 5'h01;
    localparam int BIT_EN = 7;
    localparam int BIT_LH = 4;
    localparam int BIT_LL = 3;
    localparam int BIT_RWL = 2;
    localparam int BIT_WL = 1;
    localparam int SEL_HI = 7;
    localparam int SEL_LO = 6;
    localparam int AHI_HI = 5;
    localparam int AHI_LO = 1;
    localparam int RW_BIT = 0;
    localparam int QTR_HI = 12;
    localparam int QTR_LO = 11;
    localparam logic [2:0] CNT_LAST = 3'h7;
    localparam logic [2:0] CNT_ONE = 3'h1;
    localparam logic [1:0] WCNT_ONE = 2'h1;
    localparam logic [1:0] WCNT_SAT = 2'h2;
    localparam logic [7:0] CLR_WL_PAT = 8'h00;
    localparam logic [6:0] SET_WL_PAT = 7'h01;
    localparam logic [1:0] RWL_PAT = 2'h3;
    localparam logic [2:0] NV_PAT = 3'h2;
    localparam logic [1:0] LOCK_NONE = 2'h0;
    localparam logic [1:0] LOCK_QTR = 2'h1;
    localparam logic [1:0] LOCK_HALF = 2'h2;
    localparam logic [1:0] LOCK_FULL = 2'h3;
    localparam int CLK_PERIOD_NS = 4;
    localparam int PROG_TIME_MS = 10;
    localparam int PROG_CYCLES = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int SY_SCL = 0;
    localparam int SY_SDA = 1;
    localparam int SY_S0 = 2;
    localparam int SY_S1 = 3;
    localparam int SY_PP = 4;
    localparam int SY_W = 5;
    typedef enum logic [1:0] {
        PH_DEV = 2'b00,
        PH_ADDR = 2'b01,
        PH_DATA = 2'b10
    } tws_phase_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX = 3'b001,
        ST_ACKW = 3'b010,
        ST_ACK = 3'b011,
        ST_TX = 3'b100,
        ST_TXREL = 3'b101,
        ST_TXACK = 3'b110,
        ST_TXLOAD = 3'b111
    } tws_state_t;
endpackage

// File: tws_mem.sv
`timescale 1ns/1ns
module tws_mem #(
    parameter int AW = 13,
    parameter int DW = 8
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [DW-1:0] i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output logic [DW-1:0] o_rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule

// File: tws_flash_slave_checker.sv
`timescale 1ns/1ns
module tws_flash_slave_checker #(
    parameter int BUSY_CYCLES = tws_pkg::PROG_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_select_in_0,
    input wire logic i_select_in_1,
    input wire logic i_protect_pin,
    input wire logic o_sda,
    input wire logic o_sda_oe_n,
    input wire logic o_busy
);
    int busy_cnt_q, busy_cnt_d, low_cnt_q, low_cnt_d, stop_age_q, stop_age_d;
    logic scl_q, sda_q;
    // Stop is seen on the raw pins, so its age runs a few clocks ahead of the design.
    always_comb begin
        busy_cnt_d = o_busy ? busy_cnt_q + 1 : 0;
        low_cnt_d = o_sda_oe_n ? 0 : low_cnt_q + 1;
        stop_age_d = stop_age_q;
        if (scl_q && i_scl && !sda_q && i_sda) stop_age_d = 0;
        else if (stop_age_q < 99) stop_age_d = stop_age_q + 1;
    end
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            busy_cnt_q <= 0;
            low_cnt_q <= 0;
            stop_age_q <= 99;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            busy_cnt_q <= busy_cnt_d;
            low_cnt_q <= low_cnt_d;
            stop_age_q <= stop_age_d;
            scl_q <= i_scl;
            sda_q <= i_sda;
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    a_reset_quiet: assert property ($rose(i_nrst) |-> o_sda_oe_n && !o_busy)
        else $error("outputs active after reset");
    a_drive_low: assert property (o_sda == 1'b0)
        else $error("data pin drives high");
    a_busy_mute: assert property (o_busy |-> o_sda_oe_n)
        else $error("device drives line while busy");
    a_busy_length: assert property ($fell(o_busy) |-> busy_cnt_q == BUSY_CYCLES)
        else $error("program cycle length wrong");
    a_busy_bound: assert property (busy_cnt_q <= BUSY_CYCLES)
        else $error("program cycle too long");
    a_busy_cause: assert property ($rose(o_busy) |-> stop_age_q < 12)
        else $error("program cycle without stop");
    a_quiet_high: assert property (i_scl && $past(i_scl) |-> $stable(o_sda_oe_n))
        else $error("data changed while clock high");
    a_low_run: assert property (low_cnt_q <= 73)
        else $error("line held low past ninth bit");
    c_busy: cover property ($rose(o_busy));
    c_ack: cover property ($fell(o_sda_oe_n) ##[6:10] $rose(o_sda_oe_n));
    c_long_low: cover property (low_cnt_q == 16);
endmodule

bind tws_flash_slave tws_flash_slave_checker #(.BUSY_CYCLES(BUSY_CYCLES)) u_chk (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_scl(i_scl), .i_sda(i_sda),
    .i_select_in_0(i_select_in_0), .i_select_in_1(i_select_in_1),
    .i_protect_pin(i_protect_pin), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .o_busy(o_busy));

// File: tws_master_model.sv
`timescale 1ns/1ns
module tws_master_model (
    input wire logic i_ref_clk,
    input wire logic i_sda_wire,
    output logic o_scl,
    output logic o_sda_drv
);
    initial begin
        o_scl = 1'b1;
        o_sda_drv = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask
    // Low phase is long so the slave's late release settles before the rise.
    task automatic bit_io(input logic b, output logic s);
        o_sda_drv <= b;
        w(4);
        o_scl <= 1'b1;
        w(2);
        s = i_sda_wire;
        w(1);
        o_scl <= 1'b0;
        w(1);
    endtask
    task automatic start();
        o_sda_drv <= 1'b1;
        w(4);
        o_scl <= 1'b1;
        w(2);
        o_sda_drv <= 1'b0;
        w(2);
        o_scl <= 1'b0;
        w(1);
    endtask
    task automatic stop();
        o_sda_drv <= 1'b0;
        w(4);
        o_scl <= 1'b1;
        w(2);
        o_sda_drv <= 1'b1;
        w(2);
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask
    task automatic rbyte(input logic more, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(~more, s);
    endtask
endmodule

// File: tws_flash_slave_tb.sv
`timescale 1ns/1ns
module tws_flash_slave_tb;
    localparam int BUSY = 200;
    logic clk, nrst, sel0, sel1, pin, m_scl, m_sda, sda_w, o_sda, oe_n, busy;
    logic [8:0] exp_q[$], obs_q[$];
    logic [7:0] dq[$], eq[$];
    logic [7:0] mem[int];
    int fails, n_checks;
    assign sda_w = m_sda & (oe_n | o_sda);
    tws_flash_slave #(.BUSY_CYCLES(BUSY)) dut (.i_ref_clk(clk), .i_nrst(nrst), .i_scl(m_scl),
        .i_sda(sda_w), .i_select_in_0(sel0), .i_select_in_1(sel1), .i_protect_pin(pin),
        .o_sda(o_sda), .o_sda_oe_n(oe_n), .o_busy(busy));
    tws_master_model m (.i_ref_clk(clk), .i_sda_wire(sda_w), .o_scl(m_scl), .o_sda_drv(m_sda));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    always @(posedge clk) begin
        if (obs_q.size() > 0) check(obs_q.pop_front(), exp_q.pop_front());
    end
    task automatic print_verdict();
        repeat (2) @(posedge clk);
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic note(input logic [8:0] e, input logic [8:0] o);
        exp_q.push_back(e);
        obs_q.push_back(o);
    endtask
    function automatic logic [7:0] slv(input logic [12:0] a, input logic r);
        return {sel1, ~sel0, a[12:8], r};
    endfunction
    task automatic put(input logic [7:0] b, input logic e);
        logic a;
        m.wbyte(b, a);
        note({8'h00, e}, {8'h00, a});
    endtask
    task automatic wr(input logic [12:0] a, input logic e);
        m.start();
        put(slv(a, 1'b0), 1'b1);
        put(a[7:0], 1'b1);
        foreach (dq[i]) begin
            put(dq[i], e);
            if (!e) break;
        end
        m.stop();
    endtask
    task automatic rd(input logic [12:0] a, input logic rnd);
        logic [7:0] d;
        m.start();
        if (rnd) begin
            put(slv(a, 1'b0), 1'b1);
            put(a[7:0], 1'b1);
            m.start();
        end
        put(slv(a, 1'b1), 1'b1);
        foreach (eq[i]) begin
            m.rbyte(i < eq.size() - 1, d);
            note({1'b0, eq[i]}, {1'b0, d});
        end
        m.stop();
    endtask
    task automatic settle(input logic e);
        int n;
        n = 0;
        while (busy !== 1'b1 && n < 16) begin
            @(posedge clk);
            n++;
        end
        note({8'h00, e}, {8'h00, busy});
        if (e) begin
            m.start();
            put(slv(13'h0000, 1'b0), 1'b0);
            m.stop();
        end
        n = 0;
        while (busy !== 1'b0 && n < BUSY) begin
            @(posedge clk);
            n++;
        end
        if (busy !== 1'b0) begin
            fails++;
            $display("[FAIL] %0t program cycle did not end", $time);
            print_verdict();
        end
        if (e) begin
            m.start();
            put(slv(13'h0000, 1'b0), 1'b1);
            m.stop();
        end
    endtask
    task automatic rop(input logic [7:0] b, input logic [7:0] r, input logic bz);
        dq.delete();
        dq.push_back(b);
        wr(13'h1fff, 1'b1);
        settle(bz);
        eq.delete();
        eq.push_back(r);
        rd(13'h1fff, 1'b1);
    endtask
    // A dropped sector still runs a program cycle, so the cycle is always expected.
    task automatic sector(input logic [12:0] a, input logic locked);
        logic [12:0] x;
        dq.delete();
        for (int i = 0; i < 32; i++) begin
            dq.push_back(8'($urandom));
            x = {a[12:5], 5'(a[4:0] + 5'(i))};
            // The top byte never falls under a region lock.
            if (!locked || x == 13'h1fff) mem[x] = dq[i];
        end
        wr(a, 1'b1);
        settle(1'b1);
    endtask
    task automatic seq(input logic [12:0] a, input int n, input logic rnd);
        eq.delete();
        for (int i = 0; i < n; i++) eq.push_back(mem[int'(13'(a + 13'(i)))]);
        rd(a, rnd);
    endtask
    initial begin
        fails = 0;
        n_checks = 0;
        nrst = 1'b0;
        sel0 = 1'b0;
        sel1 = 1'b0;
        pin = 1'b0;
        void'($urandom(95));
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        for (int k = 0; k < 4; k++) begin
            {sel1, sel0} <= 2'(k);
            repeat (4) @(posedge clk);
            for (int x = 0; x < 2; x++) begin
                m.start();
                put({k[1], ~k[0] ^ x[0], 6'h00}, ~x[0]);
                m.stop();
            end
        end
        $display("select test done");
        rop(8'h00, 8'h00, 1'b0);
        dq.delete();
        dq.push_back(8'h5a);
        wr(13'h0040, 1'b0);
        settle(1'b0);
        rop(8'h02, 8'h02, 1'b0);
        rop(8'h00, 8'h00, 1'b0);
        rop(8'h02, 8'h02, 1'b0);
        $display("latch test done");
        sector(13'h0011, 1'b0);
        sector(13'h1fe7, 1'b0);
        seq(13'h1ffe, 4, 1'b1);
        seq(13'h0002, 2, 1'b0);
        $display("array test done");
        rop(8'h06, 8'h06, 1'b0);
        rop(8'h1a, 8'h1a, 1'b1);
        sector(13'h0011, 1'b1);
        seq(13'h0011, 3, 1'b1);
        rop(8'h06, 8'h1e, 1'b0);
        rop(8'h92, 8'h92, 1'b1);
        sector(13'h1fe7, 1'b1);
        sector(13'h0011, 1'b0);
        seq(13'h1fe0, 2, 1'b1);
        seq(13'h0011, 2, 1'b1);
        pin <= 1'b1;
        rop(8'h06, 8'h96, 1'b0);
        rop(8'h0a, 8'h96, 1'b0);
        pin <= 1'b0;
        rop(8'h0a, 8'h0a, 1'b1);
        sector(13'h1fe7, 1'b1);
        sector(13'h0011, 1'b0);
        seq(13'h1ff0, 2, 1'b1);
        seq(13'h1ffe, 2, 1'b1);
        seq(13'h0011, 2, 1'b1);
        $display("protect test done");
        print_verdict();
    end
endmodule
